// ---- verilog/operand_index_shift_compare_unit.sv ----
// Operand addressing, store/replace operand forms, shifts and compare.
// Assumes memory answers a read in the same cycle as mem_rd and never stalls.
`timescale 1ns/1ps
module operand_index_shift_compare_unit #(
   parameter int TIME_FAST = operand_pkg::SHIFT_FAST_CYC,
   parameter int TIME_SLOW = operand_pkg::SHIFT_SLOW_CYC
) (
   input  wire  logic                        clk,
   input  wire  logic                        reset_n,
   input  wire  logic                        clk_en,
   input  wire  logic                        start,
   input  wire  logic [1:0]                  instr_class,
   input  wire  logic [14:0]                 instr_addr,
   input  wire  logic [operand_pkg::WORD_W-1:0] mem_rdata,
   input  wire  logic [operand_pkg::WORD_W-1:0] store_operand,
   input  wire  logic [operand_pkg::WORD_W-1:0] replace_result,
   input  wire  logic [operand_pkg::HALF_W-1:0] index_wdata,
   input  wire  logic [2:0]                  index_wsel,
   input  wire  logic                        index_we,
   input  wire  logic                        jump_taken,
   input  wire  logic [14:0]                 jump_addr,
   output logic                              fetch_rd,
   output logic [14:0]                       fetch_addr,
   output logic                              mem_rd,
   output logic                              mem_wr,
   output logic [operand_pkg::WORD_W-1:0]    mem_addr,
   output logic [operand_pkg::WORD_W-1:0]    mem_wdata,
   output logic [operand_pkg::WORD_W-1:0]    operand_read,
   output logic [operand_pkg::WORD_W-1:0]    lower_word,
   output logic [operand_pkg::WORD_W-1:0]    upper_word,
   output logic                              skip_next,
   output logic                              busy,
   output logic                              done,
   output logic                              mode_unused
);
   import operand_pkg::*;

   state_type             state_q, state_d;
   logic [WORD_W-1:0]     mem_latch_q, mem_latch_d;
   logic [WORD_W-1:0]     op_latch_q, op_latch_d;
   logic [WORD_W-1:0]     lower_q, lower_d, upper_q, upper_d;
   logic [WORD_W-1:0]     addr_q, addr_d, wdata_q, wdata_d, rdop_q, rdop_d;
   logic [HALF_W-1:0]     index_q [1:7];
   logic [HALF_W-1:0]     eff_q, eff_d;
   logic [14:0]           pc_q, pc_d;
   logic [TIME_W-1:0]     timer_q, timer_d;
   logic                  rd_q, rd_d, wr_q, wr_d, skip_q, skip_d, done_q, done_d;
   logic                  unused_q, unused_d, fetch_q, fetch_d;

   logic [5:0]            func;
   logic [2:0]            skipc, mode, isel;
   logic [HALF_W-1:0]     field, ixval, eff_sum;
   logic [HALF_W:0]       raw_sum;
   logic [WORD_W-1:0]     y_sext, ycmp;
   logic [CNT_W-1:0]      cnt;
   logic [2*WORD_W-1:0]   pair, pair_r, pair_l;
   logic signed [2*WORD_W-1:0] pair_s;
   logic [WORD_W-1:0]     rot_lo, rot_up;
   logic signed [WORD_W-1:0] sy, sl, su;

   assign func  = op_latch_q[FUNC_HI:FUNC_LO];
   assign skipc = op_latch_q[SKIP_HI:SKIP_LO];
   assign mode  = op_latch_q[MODE_HI:MODE_LO];
   assign isel  = op_latch_q[INDEX_HI:INDEX_LO];
   assign field = op_latch_q[FIELD_HI:0];
   assign ixval = (isel == 3'h0) ? '0 : index_q[isel];

   // Ones complement add by end-around carry; an all-zero sum needs two zero inputs
   assign raw_sum = {1'b0, field} + {1'b0, ixval};
   assign eff_sum = raw_sum[HALF_W-1:0] + {{(HALF_W-1){1'b0}}, raw_sum[HALF_W]};

   assign y_sext = {{HALF_W{eff_q[HALF_SIGN]}}, eff_q};
   assign cnt    = eff_q[CNT_W-1:0];

   // Shift datapath
   assign pair   = {upper_q, lower_q};
   assign pair_s = signed'(pair);
   assign pair_r = (2*WORD_W)'(pair_s >>> cnt);
   assign pair_l = (pair << (cnt % (2*WORD_W))) | (pair >> ((2*WORD_W) - (cnt % (2*WORD_W))));
   assign rot_lo = (lower_q << (cnt % WORD_W)) | (lower_q >> (WORD_W - (cnt % WORD_W)));
   assign rot_up = (upper_q << (cnt % WORD_W)) | (upper_q >> (WORD_W - (cnt % WORD_W)));

   assign ycmp = rdop_q;
   assign sy = signed'(ycmp);
   assign sl = signed'(lower_q);
   assign su = signed'(upper_q);

   function automatic logic [TIME_W-1:0] shift_time(input logic [CNT_W-1:0] c);
      if (c < 6'h1C && c[2] == 1'b0) begin
         shift_time = TIME_W'(TIME_FAST - 2);
      end else begin
         shift_time = TIME_W'(TIME_SLOW - 2);
      end
   endfunction

   always_comb begin
      state_d     = state_q;
      mem_latch_d = mem_latch_q;
      op_latch_d  = op_latch_q;
      lower_d     = lower_q;
      upper_d     = upper_q;
      addr_d      = addr_q;
      wdata_d     = wdata_q;
      rdop_d      = rdop_q;
      eff_d       = eff_q;
      pc_d        = pc_q;
      timer_d     = timer_q;
      rd_d        = 1'b0;
      wr_d        = 1'b0;
      skip_d      = skip_q;
      done_d      = 1'b0;
      unused_d    = unused_q;
      fetch_d     = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (start) begin
               fetch_d = 1'b1;
               state_d = ST_LATCH;
            end
         end
         ST_LATCH: begin
            mem_latch_d = mem_rdata;
            state_d     = ST_DECODE;
         end
         ST_DECODE: begin
            op_latch_d = mem_latch_q;
            state_d    = ST_EXEC;
         end
         ST_EXEC: begin
            eff_d    = eff_sum;
            addr_d   = {{HALF_W{1'b0}}, eff_sum};
            skip_d   = 1'b0;
            unused_d = 1'b0;
            if (instr_class == CLS_REPLACE) begin
               if (mode == 3'h0 || mode == 3'h4 || mode == 3'h7) begin
                  unused_d = 1'b1;
                  state_d  = ST_DONE;
               end else begin
                  rd_d    = 1'b1;
                  state_d = ST_RMW;
               end
            end else if (instr_class == CLS_STORE) begin
               state_d = ST_DONE;
               case (mode)
                  3'h0: lower_d = store_operand;
                  3'h4: upper_d = store_operand;
                  default: begin
                     rd_d    = 1'b1;
                     state_d = ST_RMW;
                  end
               endcase
            end else begin
               timer_d = '0;
               state_d = ST_RMW;
            end
         end
         ST_RMW: begin
            if (instr_class == CLS_STORE) begin
               wr_d    = 1'b1;
               state_d = ST_DONE;
               case (mode)
                  3'h1: wdata_d = {mem_rdata[WORD_W-1:HALF_W], store_operand[HALF_W-1:0]};
                  3'h2: wdata_d = {store_operand[HALF_W-1:0], mem_rdata[HALF_W-1:0]};
                  3'h3: wdata_d = store_operand;
                  3'h5: wdata_d = {mem_rdata[WORD_W-1:HALF_W], ~store_operand[HALF_W-1:0]};
                  3'h6: wdata_d = {~store_operand[HALF_W-1:0], mem_rdata[HALF_W-1:0]};
                  default: wdata_d = ~store_operand;
               endcase
            end else if (instr_class == CLS_REPLACE) begin
               case (mode)
                  3'h1: rdop_d = {{HALF_W{1'b0}}, mem_rdata[HALF_W-1:0]};
                  3'h2: rdop_d = {{HALF_W{1'b0}}, mem_rdata[WORD_W-1:HALF_W]};
                  3'h5: rdop_d = {{HALF_W{mem_rdata[HALF_SIGN]}}, mem_rdata[HALF_W-1:0]};
                  3'h6: rdop_d = {{HALF_W{mem_rdata[WORD_SIGN]}}, mem_rdata[WORD_W-1:HALF_W]};
                  default: rdop_d = mem_rdata;
               endcase
               wdata_d = mem_rdata;
               state_d = ST_DONE;
            end else begin
               // Shifts work in the timed phase; compare loads Y and leaves after one cycle
               if (timer_q == '0) begin
                  rdop_d = y_sext;
                  case (func)
                     OP_RSH_LOWER: lower_d = WORD_W'(sl >>> cnt);
                     OP_RSH_UPPER: upper_d = WORD_W'(su >>> cnt);
                     OP_RSH_PAIR: {upper_d, lower_d} = pair_r;
                     OP_LSH_LOWER: lower_d = rot_lo;
                     OP_LSH_UPPER: upper_d = rot_up;
                     OP_LSH_PAIR: {upper_d, lower_d} = pair_l;
                     default: ;
                  endcase
               end
               if (func == OP_COMPARE) begin
                  state_d = ST_DONE;
               end else if (timer_q == shift_time(cnt)) begin
                  state_d = ST_DONE;
               end else begin
                  timer_d = timer_q + TIME_W'(1);
               end
            end
         end
         ST_DONE: begin
            if (instr_class == CLS_REPLACE && !unused_q && !wr_q) begin
               case (mode)
                  3'h1, 3'h5: wdata_d = {wdata_q[WORD_W-1:HALF_W], replace_result[HALF_W-1:0]};
                  3'h2, 3'h6: wdata_d = {replace_result[HALF_W-1:0], wdata_q[HALF_W-1:0]};
                  default: wdata_d = replace_result;
               endcase
               wr_d = 1'b1;
            end else begin
               if (instr_class == CLS_OTHER && func == OP_COMPARE) begin
                  case (skipc)
                     3'h0: skip_d = 1'b0;
                     3'h1: skip_d = 1'b1;
                     3'h2: skip_d = (sy <= sl);
                     3'h3: skip_d = (sy > sl);
                     3'h4: skip_d = (sy > su) && (sy <= sl);
                     3'h5: skip_d = !((sy > su) && (sy <= sl));
                     3'h6: skip_d = (sy <= su);
                     default: skip_d = (sy > su);
                  endcase
               end
               // Next fetch address: sequential, +2 on skip, or jump target
               if (jump_taken) begin
                  pc_d = jump_addr;
               end else if (instr_class == CLS_OTHER && func == OP_COMPARE && skip_d) begin
                  pc_d = pc_q + 15'h0002;
               end else begin
                  pc_d = pc_q + 15'h0001;
               end
               done_d  = 1'b1;
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q     <= ST_IDLE;
         mem_latch_q <= '0;
         op_latch_q  <= '0;
         lower_q     <= '0;
         upper_q     <= '0;
         addr_q      <= '0;
         wdata_q     <= '0;
         rdop_q      <= '0;
         eff_q       <= '0;
         pc_q        <= '0;
         timer_q     <= '0;
         rd_q        <= 1'b0;
         wr_q        <= 1'b0;
         skip_q      <= 1'b0;
         done_q      <= 1'b0;
         unused_q    <= 1'b0;
         fetch_q     <= 1'b0;
      end else if (clk_en) begin
         state_q     <= state_d;
         mem_latch_q <= mem_latch_d;
         op_latch_q  <= op_latch_d;
         lower_q     <= lower_d;
         upper_q     <= upper_d;
         addr_q      <= addr_d;
         wdata_q     <= wdata_d;
         rdop_q      <= rdop_d;
         eff_q       <= eff_d;
         pc_q        <= pc_d;
         timer_q     <= timer_d;
         rd_q        <= rd_d;
         wr_q        <= wr_d;
         skip_q      <= skip_d;
         done_q      <= done_d;
         unused_q    <= unused_d;
         fetch_q     <= fetch_d;
      end
   end

   // Index registers, written by the instruction control
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 1; i < 8; i++) begin
            index_q[i] <= '0;
         end
      end else if (clk_en && index_we && index_wsel != 3'h0) begin
         index_q[index_wsel] <= index_wdata;
      end
   end

   assign fetch_rd     = fetch_q;
   assign fetch_addr   = pc_q;
   assign mem_rd       = rd_q;
   assign mem_wr       = wr_q;
   assign mem_addr     = (state_q == ST_LATCH) ? {{HALF_W{1'b0}}, pc_q} : addr_q;
   assign mem_wdata    = wdata_q;
   assign operand_read = rdop_q;
   assign lower_word   = lower_q;
   assign upper_word   = upper_q;
   assign skip_next    = skip_q;
   assign busy         = (state_q != ST_IDLE);
   assign done         = done_q;
   assign mode_unused  = unused_q;
   wire unused_inputs = ^instr_addr;
endmodule

// ---- verilog/operand_pkg.sv ----
// Constants for the operand, index, shift and compare unit.
// Assumes a single 100 MHz clock and a master clear on reset_n.
package operand_pkg;
   localparam int WORD_W = 30;
   localparam int HALF_W = 15;
   localparam int CNT_W  = 6;
   localparam int FUNC_HI = 29;
   localparam int FUNC_LO = 24;
   localparam int SKIP_HI = 23;
   localparam int SKIP_LO = 21;
   localparam int MODE_HI = 20;
   localparam int MODE_LO = 18;
   localparam int INDEX_HI = 17;
   localparam int INDEX_LO = 15;
   localparam int FIELD_HI = 14;
   localparam int HALF_SIGN = 14;
   localparam int WORD_SIGN = 29;
   // Function codes handled here
   localparam logic [5:0] OP_RSH_LOWER = 6'h01;
   localparam logic [5:0] OP_RSH_UPPER = 6'h02;
   localparam logic [5:0] OP_RSH_PAIR  = 6'h03;
   localparam logic [5:0] OP_COMPARE   = 6'h04;
   localparam logic [5:0] OP_LSH_LOWER = 6'h05;
   localparam logic [5:0] OP_LSH_UPPER = 6'h06;
   localparam logic [5:0] OP_LSH_PAIR  = 6'h07;
   // Class codes from the instruction control
   localparam logic [1:0] CLS_OTHER   = 2'h0;
   localparam logic [1:0] CLS_STORE   = 2'h1;
   localparam logic [1:0] CLS_REPLACE = 2'h2;
   // Timing
   localparam int CLK_MHZ      = 100;
   localparam int SHIFT_FAST_US = 8;
   localparam int SHIFT_SLOW_US = 12;
   localparam int SHIFT_FAST_CYC = SHIFT_FAST_US * CLK_MHZ;
   localparam int SHIFT_SLOW_CYC = SHIFT_SLOW_US * CLK_MHZ;
   localparam int TIME_W = 11;
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_LATCH   = 3'b001,
      ST_DECODE  = 3'b011,
      ST_EXEC    = 3'b010,
      ST_RMW     = 3'b110,
      ST_DONE    = 3'b111
   } state_type;
endpackage

// ---- testbench/mem_model.sv ----
// Behavioural main memory for the operand unit: fetch and operand reads, writes.
// Assumes one request per cycle; read data stand only in the cycle of the request.
`timescale 1ns/1ps
module mem_model (
   input  wire logic        clk,
   input  wire logic        fetch_rd,
   input  wire logic [14:0] fetch_addr,
   input  wire logic        mem_rd,
   input  wire logic        mem_wr,
   input  wire logic [29:0] mem_addr,
   input  wire logic [29:0] mem_wdata,
   output logic      [29:0] mem_rdata
);
   logic [29:0] mem [0:32767];
   logic [29:0] last_q;
   initial begin
      last_q = 30'h0;
      foreach (mem[i]) mem[i] = 30'h0;
   end
   // Read data stand while the request stands; otherwise the inverse of the last value
   assign mem_rdata = fetch_rd ? mem[fetch_addr] :
                      mem_rd   ? mem[mem_addr[14:0]] : ~last_q;
   always @(posedge clk) begin
      last_q <= mem_rdata;
      if (mem_wr)
         mem[mem_addr[14:0]] <= mem_wdata;
   end
endmodule

// ---- testbench/unit_props.sv ----
// Concurrent checks on the operand unit's ports.
// Assumes one instruction in flight and clk_en held high by the bench.
`timescale 1ns/1ps
module unit_props
   import operand_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        clk_en,
   input wire logic        start,
   input wire logic [1:0]  instr_class,
   input wire logic [29:0] store_operand,
   input wire logic        fetch_rd,
   input wire logic        mem_rd,
   input wire logic        mem_wr,
   input wire logic [29:0] mem_addr,
   input wire logic [29:0] mem_rdata,
   input wire logic [29:0] mem_wdata,
   input wire logic [29:0] lower_word,
   input wire logic [29:0] upper_word,
   input wire logic        busy,
   input wire logic        done
);
   logic [29:0] ins_q;
   logic [29:0] lw_q;
   logic [29:0] uw_q;
   logic [2:0]  k;
   logic        cmp;
   assign k = ins_q[MODE_HI:MODE_LO];
   assign cmp = instr_class == CLS_OTHER && ins_q[FUNC_HI:FUNC_LO] == OP_COMPARE;
   // Instruction word is on the bus while the fetch request stands
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ins_q <= '0;
         lw_q <= '0;
         uw_q <= '0;
      end else begin
         if (fetch_rd) begin
            ins_q <= mem_rdata;
            lw_q <= lower_word;
            uw_q <= upper_word;
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_done_pulse;
      done |=> !done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
   property p_start_fetch;
      start && !busy && clk_en |=> fetch_rd ##1 !fetch_rd [*3];
   endproperty
   a_start_fetch: assert property (p_start_fetch) else $error("no single fetch");
   property p_addr_upper;
      mem_rd || mem_wr |-> mem_addr[29:15] == 15'h0000;
   endproperty
   a_addr_upper: assert property (p_addr_upper) else $error("address upper half set");
   property p_cmp_keeps;
      done && cmp |-> lower_word == lw_q && upper_word == uw_q;
   endproperty
   a_cmp_keeps: assert property (p_cmp_keeps) else $error("compare changed a word");
   property p_store_lower;
      done && instr_class == CLS_STORE && k == 3'h0 |-> lower_word == store_operand;
   endproperty
   a_store_lower: assert property (p_store_lower) else $error("lower word not loaded");
   property p_store_upper;
      done && instr_class == CLS_STORE && k == 3'h4 |-> upper_word == store_operand;
   endproperty
   a_store_upper: assert property (p_store_upper) else $error("upper word not loaded");
   property p_store_cpl;
      mem_wr && instr_class == CLS_STORE && k == 3'h7 |-> mem_wdata == ~store_operand;
   endproperty
   a_store_cpl: assert property (p_store_cpl) else $error("complement store wrong");
   property p_replace_unused;
      (mem_rd || mem_wr) && instr_class == CLS_REPLACE |-> !(k inside {3'h0, 3'h4, 3'h7});
   endproperty
   a_replace_unused: assert property (p_replace_unused) else $error("unused mode used");
endmodule

// ---- testbench/tb_top.sv ----
// Bench for the operand unit: store, replace, index, shift, compare, fetch.
// Assumes mem_model as memory; each instruction is planted at the pc.
`timescale 1ns/1ps
module tb_top;
   import operand_pkg::*;
   localparam int T_F = 8;
   localparam int T_S = 12;
   logic        clk, reset_n, start, index_we, jump_taken, fetch_rd;
   logic        mem_rd, mem_wr, skip_next, busy, done, mode_unused;
   logic [1:0]  instr_class;
   logic [2:0]  index_wsel;
   logic [14:0] index_wdata, jump_addr, fetch_addr, exp_pc;
   logic [29:0] mem_rdata, store_operand, replace_result, mem_addr, mem_wdata;
   logic [29:0] operand_read, lower_word, upper_word;
   int          fail_count = 0, tests_run = 0, cyc = 0, ncyc;
   operand_index_shift_compare_unit #(.TIME_FAST(T_F), .TIME_SLOW(T_S)) i_dut (
      .clk, .reset_n, .clk_en(1'b1), .start, .instr_class, .instr_addr(15'h0000),
      .mem_rdata, .store_operand, .replace_result, .index_wdata, .index_wsel,
      .index_we, .jump_taken, .jump_addr, .fetch_rd, .fetch_addr, .mem_rd, .mem_wr,
      .mem_addr, .mem_wdata, .operand_read, .lower_word, .upper_word, .skip_next,
      .busy, .done, .mode_unused);
   mem_model i_mem (.clk, .fetch_rd, .fetch_addr, .mem_rd, .mem_wr, .mem_addr,
      .mem_wdata, .mem_rdata);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic check(input logic [59:0] got, input logic [59:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [29:0] mk(logic [5:0] f, logic [2:0] j, k, b, logic [14:0] y);
      return {f, j, k, b, y};
   endfunction
   function automatic logic [59:0] ref_shift(logic [5:0] f, logic [59:0] p, int n);
      for (int i = 0; i < n; i++) begin
         case (f)
            OP_RSH_LOWER: p[29:0] = {p[29], p[29:1]};
            OP_RSH_UPPER: p[59:30] = {p[59], p[59:31]};
            OP_RSH_PAIR: p = {p[59], p[59:1]};
            OP_LSH_LOWER: p[29:0] = {p[28:0], p[29]};
            OP_LSH_UPPER: p[59:30] = {p[58:30], p[59]};
            default: p = {p[58:0], p[59]};
         endcase
      end
      return p;
   endfunction
   // One instruction from start to done; the next pc follows skip and jump
   task automatic run(input logic [1:0] cls, input logic [29:0] ins, op, rr,
                      input logic jt, sk);
      @(posedge clk);
      i_mem.mem[exp_pc] = ins;
      instr_class <= cls;
      store_operand <= op;
      replace_result <= rr;
      jump_taken <= jt;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      ncyc = 0;
      while (ncyc < 3000) begin
         #1;
         if (fetch_rd === 1'b1) check(60'(fetch_addr), 60'(exp_pc));
         if (done === 1'b1) break;
         @(posedge clk);
         ncyc++;
      end
      if (ncyc == 3000) check(60'h0, 60'h1);
      exp_pc = jt ? jump_addr : exp_pc + (sk ? 15'h0002 : 15'h0001);
   endtask
   task automatic st(input logic [2:0] k, b, input logic [14:0] y, input logic [29:0] d);
      run(CLS_STORE, mk(6'h0C, 3'h0, k, b, y), d, '0, 1'b0, 1'b0);
   endtask
   task automatic set_index(input logic [2:0] s, input logic [14:0] v);
      @(posedge clk);
      index_we <= 1'b1;
      index_wsel <= s;
      index_wdata <= v;
      @(posedge clk);
      index_we <= 1'b0;
   endtask
   task automatic t_store;
      logic [29:0] w, d, e;
      w = {15'h1111, 15'h2222};
      d = {15'h3333, 15'h4444};
      for (int k = 0; k < 8; k++) begin
         i_mem.mem[15'h1000] = w;
         st(3'(k), 3'h0, 15'h1000, d);
         case (k)
            1: e = {w[29:15], d[14:0]};
            2: e = {d[14:0], w[14:0]};
            3: e = d;
            5: e = {w[29:15], ~d[14:0]};
            6: e = {~d[14:0], w[14:0]};
            7: e = ~d;
            default: e = w;
         endcase
         check(60'(i_mem.mem[15'h1000]), 60'(e));
         if (k == 0) check(60'(lower_word), 60'(d));
         if (k == 4) check(60'(upper_word), 60'(d));
      end
      $display("store modes finished");
   endtask
   task automatic t_index;
      set_index(3'h2, 15'h0005);
      set_index(3'h3, 15'h7FFE);
      set_index(3'h4, 15'h0003);
      st(3'h3, 3'h2, 15'h1010, 30'h23456789);
      check(60'(i_mem.mem[15'h1015]), 60'h23456789);
      st(3'h3, 3'h0, 15'h1020, 30'h23456789);
      check(60'(i_mem.mem[15'h1020]), 60'h23456789);
      st(3'h3, 3'h3, 15'h0001, 30'h23456789);
      check(60'(i_mem.mem[15'h7FFF]), 60'h23456789);
      check(60'(i_mem.mem[15'h0000] == 30'h23456789), 60'h0);
      st(3'h3, 3'h4, 15'h7FFE, 30'h23456789);
      check(60'(i_mem.mem[15'h0002]), 60'h23456789);
      $display("indexing finished");
   endtask
   task automatic t_replace;
      logic [29:0] w, r, rd, e;
      w = {15'h4001, 15'h5234};
      r = 30'h15552ABC;
      for (int k = 0; k < 8; k++) begin
         i_mem.mem[15'h2000] = w;
         run(CLS_REPLACE, mk(6'h14, 3'h0, 3'(k), 3'h0, 15'h2000), '0, r, 1'b0, 1'b0);
         rd = w;
         e = w;
         case (k)
            1, 5: begin
               rd = {{15{k == 5 && w[14]}}, w[14:0]};
               e = {w[29:15], r[14:0]};
            end
            2, 6: begin
               rd = {{15{k == 6 && w[29]}}, w[29:15]};
               e = {r[14:0], w[14:0]};
            end
            3: e = r;
            default: ;
         endcase
         check(60'(i_mem.mem[15'h2000]), 60'(e));
         check(60'(mode_unused), 60'(k == 0 || k == 4 || k == 7));
         if (k inside {1, 2, 3, 5, 6}) check(60'(operand_read), 60'(rd));
      end
      $display("replace modes finished");
   endtask
   task automatic t_shift;
      logic [5:0]  f [6] = '{OP_RSH_LOWER, OP_RSH_UPPER, OP_RSH_PAIR,
                             OP_LSH_LOWER, OP_LSH_UPPER, OP_LSH_PAIR};
      logic [14:0] y [6] = '{15'h7FC3, 15'h003F, 15'h0004, 15'h0001, 15'h0021, 15'h001F};
      for (int i = 0; i < 6; i++) begin
         st(3'h0, 3'h0, 15'h0000, 30'h200000F3);
         st(3'h4, 3'h0, 15'h0000, 30'h30000F01);
         run(CLS_OTHER, mk(f[i], 3'h0, 3'h0, 3'h0, y[i]), '0, '0, 1'b0, 1'b0);
         check({upper_word, lower_word},
               ref_shift(f[i], {30'h30000F01, 30'h200000F3}, int'(y[i][5:0])));
      end
      $display("shifts finished");
   endtask
   task automatic t_timing;
      int n [8] = '{0, 3, 4, 11, 12, 27, 28, 63};
      int base;
      base = 0;
      for (int i = 0; i < 8; i++) begin
         run(CLS_OTHER, mk(OP_LSH_LOWER, 3'h0, 3'h0, 3'h0, 15'(n[i])), '0, '0, 1'b0, 1'b0);
         if (i == 0) base = ncyc;
         check(60'(ncyc - base), 60'((n[i] >= 28 || n[i][2]) ? T_S - T_F : 0));
      end
      $display("shift timing finished");
   endtask
   task automatic t_compare;
      logic [14:0] yv [2] = '{15'd50, 15'h7FF0};
      logic [7:0]  tbl;
      int          ys;
      st(3'h0, 3'h0, 15'h0000, 30'd100);
      st(3'h4, 3'h0, 15'h0000, 30'd10);
      for (int v = 0; v < 2; v++) begin
         for (int j = 0; j < 8; j++) begin
            ys = int'($signed(yv[v]));
            tbl = {ys > 10, ys <= 10, !(ys <= 100 && ys > 10), ys <= 100 && ys > 10,
                   ys > 100, ys <= 100, 1'b1, 1'b0};
            run(CLS_OTHER, mk(OP_COMPARE, 3'(j), 3'h0, 3'h0, yv[v]), '0, '0, 1'b0, tbl[j]);
            check(60'(skip_next), 60'(tbl[j]));
            check({upper_word, lower_word}, {30'd10, 30'd100});
         end
      end
      $display("compare finished");
   endtask
   initial begin
      reset_n = 1'b0;
      start = 1'b0;
      index_we = 1'b0;
      jump_taken = 1'b0;
      instr_class = CLS_OTHER;
      index_wsel = 3'h0;
      index_wdata = 15'h0000;
      jump_addr = 15'h0100;
      exp_pc = 15'h0000;
      store_operand = 30'h0;
      replace_result = 30'h0;
      repeat (10) @(posedge clk);
      #1;
      check({upper_word, lower_word}, 60'h0);
      check(60'({done, busy, fetch_rd, mem_wr}), 60'h0);
      @(posedge clk);
      reset_n <= 1'b1;
      t_store();
      t_index();
      t_replace();
      t_shift();
      t_timing();
      t_compare();
      st(3'h0, 3'h0, 15'h0000, 30'h1);
      run(CLS_STORE, mk(6'h0C, 3'h0, 3'h0, 3'h0, 15'h0000), 30'h2, '0, 1'b1, 1'b0);
      st(3'h0, 3'h0, 15'h0000, 30'h3);
      $display("jump finished");
      final_report();
   end
endmodule
bind operand_index_shift_compare_unit unit_props i_props (
   .clk, .reset_n, .clk_en, .start, .instr_class, .store_operand, .fetch_rd, .mem_rd,
   .mem_wr, .mem_addr, .mem_rdata, .mem_wdata, .lower_word, .upper_word, .busy, .done);
